// File: rtl/adc_regs_consts.svh
// Constants for the converter status and mode register block.
`ifndef ADC_REGS_CONSTS_SVH
`define ADC_REGS_CONSTS_SVH
`define SEL_STAT_CMD 2'h0
`define SEL_MODE 2'h1
`define SEL_FILTER 2'h2
`define SEL_DATA 2'h3
`define MODE_RESET 8'h02
`define STATUS_FIXED 3'h1
`define CHAN_RESET 2'h0
`define CHAN_DIFF 2'h0
`define CHAN_RSVD 2'h1
`define CHAN_SHORT 2'h2
`define CHAN_SUPPLY 2'h3
`define MD_CONTINUOUS 2'h0
`define MD_SINGLE 2'h1
`define MD_STANDBY 2'h3
`define REG_BITS 5'h08
`define DATA_BITS 5'h10
`define ONES_TO_RESET 6'h20
`define PAD_BYTE 8'h00
`endif

// File: rtl/adc_regs_pkg.sv
// Types shared by the converter status and mode register block.
package adc_regs_pkg;
	typedef struct packed {
		logic wen;
		logic zero;
		logic [1:0] register_select;
		logic rd;
		logic cread;
		logic [1:0] channel_code;
	} command_t;

	typedef struct packed {
		logic [1:0] operating_mode_field;
		logic [1:0] input_range_field;
		logic burnout_current_enable;
		logic zero_hi;
		logic buffer_enable;
		logic zero_lo;
	} mode_t;

	typedef struct packed {
		logic pending;
		logic error;
		logic [2:0] fixed;
		logic part_variant_bit;
		logic [1:0] channel_code;
	} status_t;

	typedef enum logic [1:0] {PH_COMMAND, PH_WRITE, PH_READ} phase_t;
endpackage : adc_regs_pkg

// File: rtl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module pin_sync3 #(
	parameter logic INIT = 1'b0
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic s1_q, s2_q, s3_q, level_q;
	logic level_d;

	// The level moves only once the second and third stages agree.
	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			level_q <= INIT;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

	assign level_o = level_q;
endmodule : pin_sync3

// File: rtl/adc_status_mode_registers.sv
// Serial-port status and mode registers of the sigma-delta converter.
// Functional notes
// - Status register is eight bits, read only.
// - Registers shift out most significant bit first.
// - Status bit 3 is one, bits 5:4 zero.
// - New result clears the pending flag.
// - Data read or imminent update sets pending.
// - Entering power-down sets the pending flag.
// - Serial output pin also shows ready state.
// - Error flag updates with pending, marks clamping.
// - Conversion-starting write clears the error flag.
// - Status bit 2 is fixed part variant.
// - Status bits 1:0 show converted channel.
// - Mode register eight bits, read/write, select 01.
// - Mode write resets filter, sets pending flag.
// - Mode bit layout with fixed zero bits.
// - Mode register resets to 0x02.
// - Status resets pending one, error zero.
// - Register select decodes four registers.
// - Channel codes: differential, reserved, short, supply.
`timescale 1ns/1ps
`include "adc_regs_consts.svh"
module adc_status_mode_registers import adc_regs_pkg::*; #(
	// Arbitrary variant value.
	parameter logic PART_VARIANT = 1'b1
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic din_i,
	input wire logic cs_n_i,
	output logic dout_rdy_o,
	output logic dout_oe_o,
	input wire logic [15:0] data_word_i,
	input wire logic result_valid_i,
	input wire logic result_clamped_i,
	input wire logic result_soon_i,
	output mode_t config_o,
	output logic [1:0] channel_o,
	output logic powerdown_o,
	output logic filter_reset_o
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and clock edge detection.

	logic sclk_s, din_s, cs_n_s;

	pin_sync3 #(.INIT(1'b1)) sclk_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(sclk_i),
		.level_o(sclk_s)
	);

	pin_sync3 #(.INIT(1'b0)) din_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(din_i),
		.level_o(din_s)
	);

	pin_sync3 #(.INIT(1'b1)) cs_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(cs_n_i),
		.level_o(cs_n_s)
	);

	logic sclk_prev_q;
	logic sclk_rise, sclk_fall;

	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;

	////////////////////////////////////////////////////////////////////////
	// State.

	phase_t phase_q, phase_d;
	logic [7:0] shift_q, shift_d;
	logic [4:0] cnt_q, cnt_d;
	logic [4:0] len_q, len_d;
	logic [1:0] sel_q, sel_d;
	logic [16:0] tx_q, tx_d;
	logic [5:0] ones_q, ones_d;
	mode_t mode_q, mode_d;
	logic [1:0] chan_q, chan_d;
	logic pend_q, pend_d;
	logic err_q, err_d;
	logic dout_q, dout_d;
	logic frst_q, frst_d;

	status_t status_w;
	command_t cmd_w;
	mode_t wr_mode_w;
	logic mode_wr, data_rd_done, chan_chg, serial_rst, load_tx;
	logic pend_set, err_set;
	logic [15:0] rd_val;

	assign status_w = '{
		pending: pend_q,
		error: err_q,
		fixed: `STATUS_FIXED,
		part_variant_bit: PART_VARIANT,
		channel_code: chan_q
	};

	assign cmd_w = command_t'({shift_q[6:0], din_s});

	always_comb begin
		wr_mode_w = mode_t'({shift_q[6:0], din_s});
		wr_mode_w.zero_hi = 1'b0;
		wr_mode_w.zero_lo = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		phase_d = phase_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		len_d = len_q;
		sel_d = sel_q;
		tx_d = tx_q;
		ones_d = ones_q;
		mode_d = mode_q;
		chan_d = chan_q;
		mode_wr = 1'b0;
		data_rd_done = 1'b0;
		chan_chg = 1'b0;
		serial_rst = 1'b0;
		load_tx = 1'b0;
		rd_val = 16'h0000;
		if (cs_n_s) begin
			phase_d = PH_COMMAND;
			cnt_d = 5'h00;
		end else if (sclk_rise) begin
			ones_d = din_s ? ones_q + 6'h01 : 6'h00;
			serial_rst = din_s && (ones_q + 6'h01 == `ONES_TO_RESET);
			unique case (phase_q)
				PH_COMMAND: begin
					// A leading one holds the port at the first bit.
					if (cnt_q != 5'h00 || !din_s) begin
						shift_d = {shift_q[6:0], din_s};
						cnt_d = cnt_q + 5'h01;
					end
					if (cnt_q == `REG_BITS - 5'h01) begin
						cnt_d = 5'h00;
						sel_d = cmd_w.register_select;
						chan_d = cmd_w.channel_code;
						chan_chg = cmd_w.channel_code != chan_q;
						if (cmd_w.rd) begin
							phase_d = PH_READ;
							load_tx = 1'b1;
							len_d = `REG_BITS;
							unique case (cmd_w.register_select)
								`SEL_STAT_CMD: rd_val = {status_w, `PAD_BYTE};
								`SEL_MODE: rd_val = {mode_q, `PAD_BYTE};
								`SEL_FILTER: rd_val = 16'h0000;
								`SEL_DATA: begin
									rd_val = data_word_i;
									len_d = `DATA_BITS;
								end
							endcase
						end else if (cmd_w.register_select != `SEL_STAT_CMD) begin
							phase_d = PH_WRITE;
						end
					end
				end
				PH_WRITE: begin
					shift_d = {shift_q[6:0], din_s};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == `REG_BITS - 5'h01) begin
						phase_d = PH_COMMAND;
						cnt_d = 5'h00;
						if (sel_q == `SEL_MODE) begin
							mode_wr = 1'b1;
							mode_d = wr_mode_w;
						end
					end
				end
				PH_READ: begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == len_q - 5'h01) begin
						phase_d = PH_COMMAND;
						cnt_d = 5'h00;
						data_rd_done = sel_q == `SEL_DATA;
					end
				end
				default: begin
					phase_d = PH_COMMAND;
					cnt_d = 5'h00;
				end
			endcase
		end else if (sclk_fall && phase_q == PH_READ) begin
			tx_d = {tx_q[15:0], 1'b0};
		end
		if (load_tx) begin
			tx_d = {pend_q, rd_val};
		end
		if (serial_rst) begin
			phase_d = PH_COMMAND;
			cnt_d = 5'h00;
			ones_d = 6'h00;
			mode_d = mode_t'(`MODE_RESET);
			chan_d = `CHAN_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pending and error flags; a set in the same cycle beats a clear.

	assign pend_set = mode_wr | data_rd_done | result_soon_i | serial_rst;
	assign err_set = result_valid_i & result_clamped_i;

	always_comb begin
		pend_d = pend_q;
		err_d = err_q;
		if (pend_set) begin
			pend_d = 1'b1;
		end else if (result_valid_i) begin
			pend_d = 1'b0;
		end
		if (err_set) begin
			err_d = 1'b1;
		end else if (mode_wr | result_valid_i | serial_rst) begin
			err_d = 1'b0;
		end
		dout_d = (phase_d == PH_READ) ? tx_d[16] : pend_d;
		frst_d = mode_wr | chan_chg | serial_rst;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sclk_prev_q <= 1'b1;
			phase_q <= PH_COMMAND;
			shift_q <= 8'h00;
			cnt_q <= 5'h00;
			len_q <= `REG_BITS;
			sel_q <= `SEL_STAT_CMD;
			tx_q <= 17'h00000;
			ones_q <= 6'h00;
			mode_q <= mode_t'(`MODE_RESET);
			chan_q <= `CHAN_RESET;
			pend_q <= 1'b1;
			err_q <= 1'b0;
			dout_q <= 1'b1;
			frst_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			phase_q <= phase_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			len_q <= len_d;
			sel_q <= sel_d;
			tx_q <= tx_d;
			ones_q <= ones_d;
			mode_q <= mode_d;
			chan_q <= chan_d;
			pend_q <= pend_d;
			err_q <= err_d;
			dout_q <= dout_d;
			frst_q <= frst_d;
		end
	end

	assign dout_rdy_o = dout_q;
	assign dout_oe_o = ~cs_n_s;
	assign config_o = mode_q;
	assign channel_o = chan_q;
	assign powerdown_o = mode_q.operating_mode_field == `MD_STANDBY;
	assign filter_reset_o = frst_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence mode_write_s;
		mode_wr && !serial_rst;
	endsequence

	sequence result_only_s;
		result_valid_i && !pend_set;
	endsequence

	sequence cmd_done_s;
		!cs_n_s && sclk_rise && phase_q == PH_COMMAND && cnt_q == `REG_BITS - 5'h01 && !serial_rst;
	endsequence

	status_fixed_a: assert property (status_w.fixed == `STATUS_FIXED
		&& status_w.part_variant_bit == PART_VARIANT)
		else $error("status fixed bits wrong");

	status_ro_a: assert property (!(phase_q == PH_WRITE && sel_q == `SEL_STAT_CMD))
		else $error("status register entered a write data phase");

	status_chan_a: assert property (cmd_done_s |=>
		status_w.channel_code == $past(cmd_w.channel_code))
		else $error("status channel differs from last command");

	mode_only_write_a: assert property (!mode_wr && !serial_rst |=> $stable(config_o))
		else $error("mode changed without a mode write");

	pend_clear_a: assert property (result_only_s |=> !pend_q ##0 dout_rdy_o == (phase_q == PH_READ ? tx_q[16] : 1'b0))
		else $error("pending not cleared by result");

	mode_write_a: assert property (mode_write_s |=> pend_q && filter_reset_o && !config_o.zero_hi)
		else $error("mode write did not restart conversion");

	err_clear_a: assert property (mode_write_s ##0 !err_set |=> !err_q)
		else $error("error flag not cleared by mode write");

	err_set_a: assert property (err_set |=> err_q ##1 (err_q || $past(mode_wr || result_valid_i || serial_rst)))
		else $error("clamped result did not set error");

	data_read_a: assert property (data_rd_done |=> pend_q)
		else $error("data read did not set pending");

	standby_pend_a: assert property (mode_write_s ##0 wr_mode_w.operating_mode_field == `MD_STANDBY
		|=> powerdown_o && pend_q)
		else $error("power-down entry did not set pending");

	pin_ready_a: assert property (phase_q == PH_COMMAND && phase_d == PH_COMMAND
		|=> dout_rdy_o == $past(pend_d))
		else $error("ready pin does not follow pending flag");

	msb_first_a: assert property (load_tx |=> tx_q[15:8] == $past(rd_val[15:8])
		##0 (sel_q != `SEL_STAT_CMD || tx_q[15:8] == $past(status_w)))
		else $error("read value not loaded msb first");

	reset_values_a: assert property (disable iff (1'b0) rst_i |=> rst_i ||
		(config_o == mode_t'(`MODE_RESET) && pend_q && !err_q && channel_o == `CHAN_RESET))
		else $error("reset values wrong");

endmodule : adc_status_mode_registers

// File: verification/host_port_model.sv
// Host model that drives the four-wire serial port.
`timescale 1ns/1ps
module host_port_model (
	output logic sclk_o,
	output logic din_o,
	output logic cs_n_o,
	input wire logic dout_i
);
	initial begin
		sclk_o = 1'b1;
		din_o = 1'b0;
		cs_n_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// command then data, msb first.
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n,
			output logic [15:0] rd);
		logic [23:0] sh;
		sh = {cmd, wd << (16 - n)};
		rd = 16'h0000;
		cs_n_o <= 1'b0;
		#333;
		for (int i = 0; i < 8 + n; i++) begin
			sclk_o <= 1'b0;
			#80 din_o <= sh[23 - i];
			#120 sclk_o <= 1'b1;
			#60 if (i >= 8) rd = {rd[14:0], dout_i};
			#60;
		end
		#80 din_o <= 1'b0;
		#320 cs_n_o <= 1'b1;
		#400;
	endtask : xfer
endmodule : host_port_model

// File: verification/test_adc_status_mode_registers.sv
// Self-checking bench for the status and mode register block.
`timescale 1ns/1ps
module test_adc_status_mode_registers import adc_regs_pkg::*;;
	localparam logic VARIANT = 1'b1;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk, din, cs_n, dout_rdy, dout_oe, pd, frst;
	logic [15:0] data_word = 16'h0000;
	logic valid = 1'b0;
	logic clamped = 1'b0;
	logic soon = 1'b0;
	mode_t cfg;
	logic [1:0] chan_o;
	logic [15:0] rd;
	logic [7:0] mode = 8'h02;
	int failures = 0;
	int comparisons = 0;
	int pulses = 0;
	int want_pulses = 0;
	int pending = 1;
	int err = 0;
	int chan = 0;
	integer seed = 32'hB81EA1FE;

	initial forever #20 clock_i = ~clock_i;

	// A deselected output shows the host the inverse of its current value.
	host_port_model hp (.sclk_o(sclk), .din_o(din), .cs_n_o(cs_n),
		.dout_i(dout_oe ? dout_rdy : ~dout_rdy));

	adc_status_mode_registers #(.PART_VARIANT(VARIANT)) dut (.clock_i(clock_i),
		.rst_i(rst_i), .sclk_i(sclk), .din_i(din), .cs_n_i(cs_n), .dout_rdy_o(dout_rdy),
		.dout_oe_o(dout_oe), .data_word_i(data_word), .result_valid_i(valid),
		.result_clamped_i(clamped), .result_soon_i(soon), .config_o(cfg),
		.channel_o(chan_o), .powerdown_o(pd), .filter_reset_o(frst));

	always @(posedge clock_i) if (frst === 1'b1) pulses <= pulses + 1;

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic test_done();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	task automatic xf(input logic [5:0] op, input logic [15:0] wd, input int n);
		hp.xfer({op, chan[1:0]}, wd, n, rd);
	endtask : xf

	task automatic rd_stat();
		xf(6'h02, 16'h0000, 8);
		check(rd[7:0], {pending[0], err[0], 3'h1, VARIANT, chan[1:0]});
	endtask : rd_stat

	task automatic pulse(input logic c, input logic s);
		@(posedge clock_i);
		valid <= !s;
		clamped <= c;
		soon <= s;
		@(posedge clock_i);
		valid <= 1'b0;
		clamped <= 1'b0;
		soon <= 1'b0;
		repeat (4) @(posedge clock_i);
		if (!s) begin
			pending = 0;
			err = c;
		end else
			pending = 1;
		check(dout_rdy, pending[0]);
		rd_stat();
	endtask : pulse

	task automatic wr_mode(input logic [7:0] m);
		xf(6'h04, {8'h00, m & 8'hFB}, 8);
		mode = m & 8'hFA;
		pending = 1;
		err = 0;
		want_pulses++;
		repeat (4) @(posedge clock_i);
		check(cfg, mode);
		check(pd, mode[7:6] == 2'h3);
		check(pulses, want_pulses);
		xf(6'h06, 16'h0000, 8);
		check(rd[7:0], mode);
		rd_stat();
	endtask : wr_mode

	initial begin
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		check(dout_rdy, 1'b1);
		check(dout_oe, 1'b0);
		check(cfg, 8'h02);
		rd_stat();
		xf(6'h06, 16'h0000, 8);
		check(rd[7:0], 8'h02);
		for (int c = 0; c < 4; c++) begin
			chan = 3 - c;
			xf(6'h00, 16'h0000, 0);
			want_pulses++;
			repeat (4) @(posedge clock_i);
			check(chan_o, chan[1:0]);
			check(pulses, want_pulses);
			rd_stat();
		end
		for (int k = 0; k < 4; k++) wr_mode({2'(3 - k), 6'($random(seed))});
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		pulse(1'b0, 1'b0);
		data_word <= 16'($random(seed));
		xf(6'h0E, 16'h0000, 16);
		check(rd, data_word);
		pending = 1;
		rd_stat();
		pulse(1'b1, 1'b0);
		// mode write clears the error flag.
		wr_mode(8'h12);
		xf(6'h0A, 16'h0000, 8);
		check(rd[7:0], 8'h00);
		pulse(1'b1, 1'b0);
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		pending = 1;
		err = 0;
		check(dout_rdy, 1'b1);
		check(dout_oe, 1'b0);
		check(cfg, 8'h02);
		rd_stat();
		test_done();
	end

	initial begin
		repeat (30000) @(posedge clock_i);
		failures++;
		test_done();
	end
endmodule : test_adc_status_mode_registers
